// *** design/smf_regs.svh ***
// Register offset, field positions, reset values and timing counts of the supply monitor
`ifndef SMF_REGS_SVH
`define SMF_REGS_SVH
`define SMF_CTRL_ADDR 8'hDF
`define SMF_CTRL_RESET 8'hDE
`define SMF_DTRIP_RESET 2'h3
`define SMF_ATRIP_RESET 2'h3
`define SMF_ENABLE_RESET 1'b0
`define SMF_BIT_DIG_OK 7
`define SMF_BIT_ANA_OK 6
`define SMF_BIT_FLAG 5
`define SMF_BIT_DTRIP_HI 4
`define SMF_BIT_DTRIP_LO 3
`define SMF_BIT_ATRIP_HI 2
`define SMF_BIT_ATRIP_LO 1
`define SMF_BIT_ENABLE 0
`define SMF_CLK_HZ 50000000
`define SMF_RECOVER_MS 250
`define SMF_RECOVER_CYCLES ((`SMF_CLK_HZ / 1000) * `SMF_RECOVER_MS)
`define SMF_GLITCH_CYCLES 4
`endif

// *** design/smf_pkg.sv ***
// Types shared by the supply monitor flag logic
package smf_pkg;
   // Trip point selection codes
   typedef enum logic [1:0] {
      TRIP_4V63 = 2'h0,
      TRIP_3V08 = 2'h1,
      TRIP_2V93 = 2'h2,
      TRIP_2V63 = 2'h3
   } smf_trip_type;
   // Recovery sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_LOW = 2'h1,
      ST_RECOVER = 2'h2
   } smf_state_type;
endpackage

// *** design/smf_glitch_filter.sv ***
// Synchroniser and glitch filter for one comparator output
`timescale 1ns/1ps
`include "smf_regs.svh"
module smf_glitch_filter #(
   parameter int FILTER_CYCLES = `SMF_GLITCH_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic raw_in,
   output logic filt_q
);
   // Counter width
   localparam int CW = $clog2(FILTER_CYCLES + 1);
   // Refuse a filter too short to act
   if (FILTER_CYCLES < 1) begin : g_bad_filter
      $error("FILTER_CYCLES must be at least one");
   end
   logic sync1_q; // First stage, read only by second
   logic sync2_q; // Second stage
   logic [CW-1:0] cnt_q; // Cycles new level has held
   // Two-flop synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end
   // Output follows only a level held for the filter time
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         filt_q <= 1'b1;
      end else if (sync2_q == filt_q) begin
         cnt_q <= '0;
      end else if (cnt_q == CW'(FILTER_CYCLES - 1)) begin
         cnt_q <= '0;
         filt_q <= sync2_q;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end
endmodule // smf_glitch_filter

// *** design/smf_supply_monitor.sv ***
// Supply monitor control register, low-supply flag and 250 ms recovery timer
`timescale 1ns/1ps
`include "smf_regs.svh"
module smf_supply_monitor #(
   parameter int RECOVER_CYCLES = `SMF_RECOVER_CYCLES,
   parameter int FILTER_CYCLES = `SMF_GLITCH_CYCLES
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic DIG_CMP_IN,
   input wire logic ANA_CMP_IN,
   input wire logic IRQ_ENABLE,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   output logic [1:0] DIG_TRIP_SEL,
   output logic [1:0] ANA_TRIP_SEL,
   output logic MONITOR_EN,
   output logic IRQ_REQ
);
   // Counter width
   localparam int RW = $clog2(RECOVER_CYCLES + 1);
   // Refuse counts the counter cannot hold
   if (RECOVER_CYCLES < 2) begin : g_bad_recover
      $error("RECOVER_CYCLES must be at least two");
   end
   // Refuse a filter the comparators cannot use
   if (FILTER_CYCLES < 1) begin : g_bad_filter
      $error("FILTER_CYCLES must be at least one");
   end
   logic dig_ok; // Filtered digital comparator
   logic ana_ok; // Filtered analog comparator
   logic dig_ok_q; // Digital comparator seen by software
   logic ana_ok_q; // Analog comparator seen by software
   logic flag_q; // Low-supply flag
   logic [1:0] dtrip_q; // Digital trip select
   logic [1:0] atrip_q; // Analog trip select
   logic en_q; // Monitor enable
   logic [RW-1:0] rec_q; // Recovery count
   smf_pkg::smf_state_type state_q; // Recovery state
   logic both_ok; // Both supplies above trip, or monitor disabled
   logic wr_hit; // Write to control register
   logic [1:0] cmp_raw; // Raw comparators, digital in bit 1
   logic [1:0] cmp_ok; // Filtered comparators, digital in bit 1
   logic expire; // Last cycle of the recovery interval

   // Recovery interval ends in this state at this count
   function automatic logic at_expiry(input smf_pkg::smf_state_type st,
      input logic [RW-1:0] cnt);
      at_expiry = (st == smf_pkg::ST_RECOVER) && (cnt == RW'(RECOVER_CYCLES - 1));
   endfunction

   // Both comparators good, always good when disabled
   assign both_ok = !en_q || (dig_ok && ana_ok);
   assign wr_hit = SFR_WR && (SFR_ADDR == `SMF_CTRL_ADDR);
   // Shared by the sequencer and the flag so both see one expiry
   assign expire = at_expiry(state_q, rec_q);
   assign cmp_raw = {DIG_CMP_IN, ANA_CMP_IN};
   assign dig_ok = cmp_ok[1];
   assign ana_ok = cmp_ok[0];

   // One synchroniser and glitch filter per comparator; raw pins feed nothing else
   for (genvar g = 0; g < 2; g++) begin : g_filt
      smf_glitch_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filt (
         .clk(CLOCK),
         .rst(RST),
         .raw_in(cmp_raw[g]),
         .filt_q(cmp_ok[g])
      );
   end

   // Comparator status bits
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         dig_ok_q <= 1'b1;
         ana_ok_q <= 1'b1;
      end else begin
         dig_ok_q <= dig_ok;
         ana_ok_q <= ana_ok;
      end
   end

   // Writable configuration fields; 5 V part ignores digital select downstream
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         // Fields start as the register's documented reset value
         dtrip_q <= `SMF_DTRIP_RESET;
         atrip_q <= `SMF_ATRIP_RESET;
         en_q <= `SMF_ENABLE_RESET;
      end else if (wr_hit) begin
         dtrip_q <= SFR_WDATA[`SMF_BIT_DTRIP_HI:`SMF_BIT_DTRIP_LO];
         atrip_q <= SFR_WDATA[`SMF_BIT_ATRIP_HI:`SMF_BIT_ATRIP_LO];
         en_q <= SFR_WDATA[`SMF_BIT_ENABLE];
      end
   end

   // Recovery sequencer
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_q <= smf_pkg::ST_IDLE;
         rec_q <= '0;
      end else begin
         unique case (state_q)
            smf_pkg::ST_IDLE: begin
               // Wait for a low supply
               if (!both_ok) begin
                  state_q <= smf_pkg::ST_LOW;
               end
            end
            smf_pkg::ST_LOW: begin
               // Both good again starts the count
               if (both_ok) begin
                  state_q <= smf_pkg::ST_RECOVER;
                  rec_q <= '0;
               end
            end
            smf_pkg::ST_RECOVER: begin
               if (!both_ok) begin
                  // Relapse restarts from scratch
                  state_q <= smf_pkg::ST_LOW;
                  rec_q <= '0;
               end else if (expire) begin
                  state_q <= smf_pkg::ST_IDLE;
                  rec_q <= '0;
               end else begin
                  rec_q <= rec_q + RW'(1);
               end
            end
            default: begin
               state_q <= smf_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Low-supply flag: any set beats any clear in the same cycle
   // A software set at expiry survives, so a request is never silently lost
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         flag_q <= 1'b0;
      end else if (!both_ok) begin
         flag_q <= 1'b1;
      end else if (wr_hit && SFR_WDATA[`SMF_BIT_FLAG]) begin
         flag_q <= 1'b1;
      end else if (expire) begin
         flag_q <= 1'b0;
      end else if (wr_hit) begin
         flag_q <= 1'b0;
      end
   end

   // Registered outputs
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         IRQ_REQ <= 1'b0;
         DIG_TRIP_SEL <= `SMF_DTRIP_RESET;
         ANA_TRIP_SEL <= `SMF_ATRIP_RESET;
         MONITOR_EN <= `SMF_ENABLE_RESET;
         SFR_RDATA <= `SMF_CTRL_RESET;
      end else begin
         IRQ_REQ <= flag_q && IRQ_ENABLE;
         DIG_TRIP_SEL <= dtrip_q;
         ANA_TRIP_SEL <= atrip_q;
         MONITOR_EN <= en_q;
         SFR_RDATA <= {dig_ok_q, ana_ok_q, flag_q, dtrip_q, atrip_q, en_q};
      end
   end

   // Low supply seen by the enabled monitor sets the flag next cycle
   flag_set_a: assert property (@(posedge CLOCK) disable iff (RST)
      !both_ok |=> flag_q) else $error("flag not set on low supply");
   // Flag never drops while the enabled monitor sees a supply low
   no_clear_low_a: assert property (@(posedge CLOCK) disable iff (RST)
      (flag_q && !both_ok) |=> flag_q) else $error("flag cleared while low");
   // Software write of one always lands, even at expiry
   sw_set_a: assert property (@(posedge CLOCK) disable iff (RST)
      (wr_hit && SFR_WDATA[`SMF_BIT_FLAG]) |=> flag_q) else $error("flag set write lost");
   // Interrupt follows flag and enable
   irq_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
      IRQ_REQ == $past(flag_q && IRQ_ENABLE)) else $error("irq gating wrong");
   // Relapse returns to waiting state
   relapse_restart_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q == smf_pkg::ST_RECOVER && !both_ok) |=> (state_q == smf_pkg::ST_LOW && rec_q == '0))
      else $error("relapse did not restart");
   // Expiry clears flag and goes idle, unless software sets it that cycle
   expiry_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q == smf_pkg::ST_RECOVER && both_ok && rec_q == RW'(RECOVER_CYCLES - 1)
      && !(wr_hit && SFR_WDATA[`SMF_BIT_FLAG])) |=> (!flag_q && state_q == smf_pkg::ST_IDLE))
      else $error("expiry did not clear");
   // Recovery begins when supplies return
   recover_start_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q == smf_pkg::ST_LOW && both_ok) |=> (state_q == smf_pkg::ST_RECOVER && rec_q == '0))
      else $error("recovery not started");
   // Status bits follow filtered comparators
   status_bits_a: assert property (@(posedge CLOCK) disable iff (RST)
      ##2 SFR_RDATA[7:6] == $past({dig_ok, ana_ok}, 2)) else $error("status bits wrong");
   // Written config reaches register
   cfg_write_a: assert property (@(posedge CLOCK) disable iff (RST)
      wr_hit |=> (en_q == $past(SFR_WDATA[0]) && atrip_q == $past(SFR_WDATA[2:1])
      && dtrip_q == $past(SFR_WDATA[4:3]))) else $error("config write lost");
   // Analog side sees the fields one cycle after the register
   trip_out_a: assert property (@(posedge CLOCK) disable iff (RST)
      ##1 (DIG_TRIP_SEL == $past(dtrip_q) && ANA_TRIP_SEL == $past(atrip_q)
      && MONITOR_EN == $past(en_q))) else $error("trip outputs stale");
   // Disabled monitor never sets flag by itself
   disabled_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
      (!en_q && !flag_q && !wr_hit) |=> !flag_q) else $error("flag set while disabled");

   // Main scenarios
   low_event_c: cover property (@(posedge CLOCK) disable iff (RST) $rose(flag_q));
   recovered_c: cover property (@(posedge CLOCK) disable iff (RST) $fell(flag_q) && !$past(wr_hit));
   relapse_c: cover property (@(posedge CLOCK) disable iff (RST)
      state_q == smf_pkg::ST_RECOVER && !both_ok);
   irq_c: cover property (@(posedge CLOCK) disable iff (RST) $rose(IRQ_REQ));
endmodule // smf_supply_monitor

// *** tb/tb_top.sv ***
// Self-checking testbench for the supply monitor flag logic
`timescale 1ns/1ps
`include "smf_regs.svh"
module tb_top;
   localparam int REC = 20; // Shortened recovery count for simulation
   logic clock = 1'b0; // 50 MHz clock
   logic rst = 1'b1; // Synchronous reset
   logic dig_cmp = 1'b1; // Digital comparator, supply good
   logic ana_cmp = 1'b1; // Analog comparator, supply good
   logic irq_en = 1'b1; // External interrupt enable
   logic [7:0] addr = 8'h00; // Register address
   logic wr_en = 1'b0; // Write strobe
   logic [7:0] wdata = 8'h00; // Write data
   logic [7:0] rdata; // Control register read value
   logic [1:0] dsel; // Digital trip select copy
   logic [1:0] asel; // Analog trip select copy
   logic mon_en; // Monitor enable copy
   logic irq; // Interrupt request
   int mismatches = 0; // Failed comparisons
   int cmp_count = 0; // All comparisons
   logic [7:0] exp_v; // Expected read value

   // Clock generator
   always #10 clock = ~clock;

   // Design under test
   smf_supply_monitor #(.RECOVER_CYCLES(REC), .FILTER_CYCLES(`SMF_GLITCH_CYCLES)) dut (
      .CLOCK(clock), .RST(rst), .DIG_CMP_IN(dig_cmp), .ANA_CMP_IN(ana_cmp),
      .IRQ_ENABLE(irq_en), .SFR_ADDR(addr), .SFR_WR(wr_en), .SFR_WDATA(wdata),
      .SFR_RDATA(rdata), .DIG_TRIP_SEL(dsel), .ANA_TRIP_SEL(asel), .MONITOR_EN(mon_en),
      .IRQ_REQ(irq));

   // Wait a number of falling edges
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Compare seen against expected
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // One register write; returns once the read value has updated
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      cyc(1);
      wr_en = 1'b0;
      cyc(1);
   endtask

   // Verdict and end of run
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Watchdog against a hung run
   initial begin
      #100us;
      mismatches++;
      stop_test();
   end

   // Main sequence
   initial begin
      cyc(4);
      rst = 1'b0;
      cyc(1);
      chk(rdata, `SMF_CTRL_RESET);
      chk({3'h0, dsel, asel, mon_en}, 8'h1E);
      chk({7'h00, irq}, 8'h00);
      // All trip codes; bits 7:6 written low must be ignored
      for (int i = 0; i < 4; i++) begin
         wr(`SMF_CTRL_ADDR, {3'h0, i[1:0], ~i[1:0], 1'b1});
         exp_v = {3'b110, i[1:0], ~i[1:0], 1'b1};
         chk(rdata, exp_v);
         chk({3'h0, dsel, asel, mon_en}, {3'h0, exp_v[4:0]});
      end
      // Other address leaves the register alone
      wr(8'hDE, 8'h00);
      chk(rdata, exp_v);
      wr(`SMF_CTRL_ADDR, 8'h01);
      chk(rdata, 8'hC1);
      // Short pulse is filtered
      dig_cmp = 1'b0;
      cyc(2);
      dig_cmp = 1'b1;
      cyc(12);
      chk(rdata, 8'hC1);
      // Sustained digital low sets the flag
      dig_cmp = 1'b0;
      cyc(12);
      chk(rdata, 8'h61);
      chk({7'h00, irq}, 8'h01);
      irq_en = 1'b0;
      cyc(2);
      chk({7'h00, irq}, 8'h00);
      irq_en = 1'b1;
      wr(`SMF_CTRL_ADDR, 8'h01);
      cyc(1);
      chk(rdata, 8'h61);
      // Recovery, interrupted by an analog relapse
      dig_cmp = 1'b1;
      cyc(15);
      chk(rdata, 8'hE1);
      ana_cmp = 1'b0;
      cyc(10);
      chk(rdata, 8'hA1);
      ana_cmp = 1'b1;
      cyc(20);
      chk(rdata, 8'hE1);
      // Software holds off until the flag has cleared
      cyc(20);
      chk(rdata, 8'hC1);
      chk({7'h00, irq}, 8'h00);
      // Software set and clear with supplies good
      wr(`SMF_CTRL_ADDR, 8'h21);
      chk(rdata, 8'hE1);
      cyc(1);
      chk({7'h00, irq}, 8'h01);
      wr(`SMF_CTRL_ADDR, 8'h01);
      chk(rdata, 8'hC1);
      // Disabled monitor ignores a low supply
      wr(`SMF_CTRL_ADDR, 8'h00);
      dig_cmp = 1'b0;
      cyc(12);
      chk({6'h00, rdata[5], irq}, 8'h00);
      dig_cmp = 1'b1;
      cyc(2);
      stop_test();
   end
endmodule // tb_top
